// ### rtl/lcp_cell.sv
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "lcp_params.svh"

module lcp_cell import lcp_pkg::*; (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [3:0] gate_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic cell_result_out,
  output logic pin_data_out,
  output logic pin_oe_n_out,
  output logic irq_out
);

  lcp_state_t q, d;
  logic [3:0] fn_gates;
  logic fn_result;
  logic addr_ok;
  logic rise_ev;
  logic fall_ev;
  logic edge_ev;

  // ****************************************
  // helpers
  // ****************************************

  // control byte as software sees it
  function automatic logic [7:0] ctl_byte(input lcp_ctl_t c, input logic out_bit);
    logic [7:0] b;
    b = `LCP_BYTE_ZERO;
    b[`LCP_CTL_EN] = c.en;
    b[`LCP_CTL_OE] = c.oe;
    b[`LCP_CTL_OUT] = out_bit;
    b[`LCP_CTL_INTP] = c.intp;
    b[`LCP_CTL_INTN] = c.intn;
    b[`LCP_CTL_MODE_HI:`LCP_CTL_MODE_LO] = c.mode;
    return b;
  endfunction

  // polarity byte, unimplemented bits stay zero
  function automatic logic [7:0] pol_byte(input lcp_pol_t p);
    logic [7:0] b;
    b = `LCP_BYTE_ZERO;
    b[`LCP_POL_INV] = p.out_inv;
    b[`LCP_POL_GATE_HI:`LCP_POL_GATE_LO] = p.gate_inv;
    return b;
  endfunction

  // ****************************************
  // function stage
  // ****************************************

  // gate inversion before the function
  assign fn_gates = gate_in ^ q.pol.gate_inv;

  lcp_func u_func (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .clear_in(!q.ctl.en),
    .mode_in(q.ctl.mode),
    .gate_in(fn_gates),
    .result_out(fn_result)
  );

  // ****************************************
  // next state
  // ****************************************

  // edges seen against last cycle's output; invert flips count as edges too
  assign rise_ev = q.cell_out & ~q.out_prev;
  assign fall_ev = ~q.cell_out & q.out_prev;
  assign edge_ev = (rise_ev & q.ctl.intp) | (fall_ev & q.ctl.intn);
  assign addr_ok = hsel_in & hready_in & htrans_in[1];

  always_comb begin
    d = q;
    // output stage: invert, then force zero when disabled
    d.cell_out = q.ctl.en & (fn_result ^ q.pol.out_inv);
    d.out_prev = q.cell_out;
    // data phase of a write; the output bit of control is not writable
    if (q.wr_pend) begin
      case (q.wr_addr)
        `LCP_OFF_CTL: begin
          d.ctl.en = hwdata_in[`LCP_CTL_EN];
          d.ctl.oe = hwdata_in[`LCP_CTL_OE];
          d.ctl.intp = hwdata_in[`LCP_CTL_INTP];
          d.ctl.intn = hwdata_in[`LCP_CTL_INTN];
          d.ctl.mode = lcp_mode_t'(hwdata_in[`LCP_CTL_MODE_HI:`LCP_CTL_MODE_LO]);
        end
        `LCP_OFF_POL: begin
          d.pol.out_inv = hwdata_in[`LCP_POL_INV];
          d.pol.gate_inv = hwdata_in[`LCP_POL_GATE_HI:`LCP_POL_GATE_LO];
        end
        `LCP_OFF_STAT: d.irq_flag = q.irq_flag & ~hwdata_in[`LCP_STAT_FLAG];
        `LCP_OFF_MASK: d.irq_mask = hwdata_in[`LCP_STAT_FLAG];
        default: d.irq_mask = q.irq_mask;
      endcase
    end
    // set after clear so a coinciding edge is not lost
    if (edge_ev) begin
      d.irq_flag = 1'b1;
    end
    d.irq = d.irq_flag & d.irq_mask;
    d.pin_oe_n = ~q.ctl.oe;
    // address phase: only whole-word writes are accepted
    d.wr_pend = addr_ok & hwrite_in & (hsize_in == `LCP_HSIZE_WORD);
    d.wr_addr = haddr_in[7:0];
    // read data registered for the data phase; unmapped reads give zero
    d.hrdata = `LCP_WORD_ZERO;
    if (addr_ok && !hwrite_in) begin
      case (haddr_in[7:0])
        `LCP_OFF_CTL: d.hrdata = {`LCP_PAD_ZERO, ctl_byte(q.ctl, q.cell_out)};
        `LCP_OFF_POL: d.hrdata = {`LCP_PAD_ZERO, pol_byte(q.pol)};
        `LCP_OFF_STAT: d.hrdata[`LCP_STAT_FLAG] = q.irq_flag;
        `LCP_OFF_MASK: d.hrdata[`LCP_STAT_FLAG] = q.irq_mask;
        default: d.hrdata = `LCP_WORD_ZERO;
      endcase
    end
    // reset clears all but the polarity settings, which survive it, and the active-low pin enable, which is set
    if (!nrst_in) begin
      d = '0;
      d.ctl = lcp_ctl_t'(`LCP_CTL_RST);
      d.pol = q.pol;
      d.pin_oe_n = 1'b1;
    end
  end

  // state register, reset is synchronous and folded into d
  always_ff @(posedge mclk_in) begin
    q <= d;
  end

  // ****************************************
  // outputs
  // ****************************************

  // zero wait states, always okay
  assign hrdata_out = q.hrdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = `LCP_HRESP_OKAY;
  assign cell_result_out = q.cell_out;
  assign pin_data_out = q.cell_out;
  assign pin_oe_n_out = q.pin_oe_n;
  assign irq_out = q.irq;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  property p_disabled_zero;
    !q.ctl.en |=> !cell_result_out;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero) else $error("disabled cell drives one");

  property p_pin_oe;
    q.ctl.oe |=> !pin_oe_n_out;
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin not driven while enabled");

  property p_pin_off;
    (!q.ctl.oe && !$past(q.ctl.oe)) |-> pin_oe_n_out;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled");

  property p_read_out;
    (addr_ok && !hwrite_in && haddr_in[7:0] == `LCP_OFF_CTL) |=> (hrdata_out[`LCP_CTL_OUT] == $past(q.cell_out));
  endproperty
  a_read_out: assert property (p_read_out) else $error("output bit read wrong");

  property p_rise_flag;
    (rise_ev && q.ctl.intp) |=> q.irq_flag;
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rising edge lost");

  property p_fall_flag;
    (fall_ev && q.ctl.intn) |=> q.irq_flag;
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("falling edge lost");

  property p_invert_path;
    q.ctl.en && q.ctl.mode == LCP_MODE_AND4 |=>
      cell_result_out == ((&($past(gate_in) ^ $past(q.pol.gate_inv))) ^ $past(q.pol.out_inv));
  endproperty
  a_invert_path: assert property (p_invert_path) else $error("inversion path wrong");

  property p_pol_reserved;
    (addr_ok && !hwrite_in && haddr_in[7:0] == `LCP_OFF_POL) |=> (hrdata_out[6:4] == 3'h0);
  endproperty
  a_pol_reserved: assert property (p_pol_reserved) else $error("reserved polarity bits set");

  property p_reset_ctl;
    @(posedge mclk_in) disable iff (1'b0)
    (!nrst_in ##1 1'b1) |-> (q.ctl == '0);
  endproperty
  a_reset_ctl: assert property (p_reset_ctl) else $error("reset handling wrong");

  property p_set_wins;
    (q.wr_pend && q.wr_addr == `LCP_OFF_STAT && hwdata_in[`LCP_STAT_FLAG] && edge_ev) |=> q.irq_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new edge");

  property p_flag_cause;
    $rose(q.irq_flag) |-> ($past(q.cell_out) != $past(q.out_prev));
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag set without edge");

  property p_irq_level;
    ##1 irq_out == ($past(d.irq_flag) & $past(d.irq_mask));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt output mismatch");

  // polarity has no reset value, so its hold across reset is checked only once software has set it
  logic pol_seen_q;
  always_ff @(posedge mclk_in) begin
    pol_seen_q <= pol_seen_q | (q.wr_pend && q.wr_addr == `LCP_OFF_POL && nrst_in);
  end

  property p_reset_pol;
    @(posedge mclk_in) disable iff (1'b0)
    (pol_seen_q && !nrst_in) |=> (q.pol == $past(q.pol));
  endproperty
  a_reset_pol: assert property (p_reset_pol) else $error("polarity lost in reset");

  property p_reset_outputs;
    @(posedge mclk_in) disable iff (1'b0)
    !nrst_in |=> (pin_oe_n_out && !cell_result_out && !irq_out && hrdata_out == '0);
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not at rest after reset");

  property p_en_write;
    (q.wr_pend && q.wr_addr == `LCP_OFF_CTL) |=> (q.ctl.en == $past(hwdata_in[`LCP_CTL_EN]));
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable bit not written");

  property p_mode_write;
    (q.wr_pend && q.wr_addr == `LCP_OFF_CTL) |=>
      (q.ctl.mode == $past(hwdata_in[`LCP_CTL_MODE_HI:`LCP_CTL_MODE_LO]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("function select not written");

  property p_gate_inv_write;
    (q.wr_pend && q.wr_addr == `LCP_OFF_POL) |=>
      (q.pol.gate_inv == $past(hwdata_in[`LCP_POL_GATE_HI:`LCP_POL_GATE_LO]));
  endproperty
  a_gate_inv_write: assert property (p_gate_inv_write) else $error("gate invert bits not written");

  property p_mask_write;
    (q.wr_pend && q.wr_addr == `LCP_OFF_MASK) |=> (q.irq_mask == $past(hwdata_in[`LCP_STAT_FLAG]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask bit not written");

  property p_or_xor;
    q.ctl.en && q.ctl.mode == LCP_MODE_OR_XOR |=>
      cell_result_out == ((($past(fn_gates[0]) | $past(fn_gates[1])) ^ ($past(fn_gates[2]) | $past(fn_gates[3])))
      ^ $past(q.pol.out_inv));
  endproperty
  a_or_xor: assert property (p_or_xor) else $error("or-xor result wrong");

  property p_sr_set;
    q.ctl.en && q.ctl.mode == LCP_MODE_SR_LATCH && (fn_gates[0] || fn_gates[1]) |=>
      cell_result_out != $past(q.pol.out_inv);
  endproperty
  a_sr_set: assert property (p_sr_set) else $error("set-reset latch ignored set");

  property p_dff2_reset;
    q.ctl.en && q.ctl.mode == LCP_MODE_DFF2_R && fn_gates[2] |=> cell_result_out == $past(q.pol.out_inv);
  endproperty
  a_dff2_reset: assert property (p_dff2_reset) else $error("two-input d flop ignored reset");

  property p_rise_quiet;
    (rise_ev && !q.ctl.intp && !q.irq_flag) |=> !q.irq_flag;
  endproperty
  a_rise_quiet: assert property (p_rise_quiet) else $error("disabled rising edge set flag");

  property p_fall_quiet;
    (fall_ev && !q.ctl.intn && !q.irq_flag) |=> !q.irq_flag;
  endproperty
  a_fall_quiet: assert property (p_fall_quiet) else $error("disabled falling edge set flag");

  property p_stat_clear;
    (q.wr_pend && q.wr_addr == `LCP_OFF_STAT && hwdata_in[`LCP_STAT_FLAG] && !edge_ev) |=> !q.irq_flag;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("flag not cleared by software");

  // read data stands for the data phase only
  property p_read_idle;
    !(addr_ok && !hwrite_in) |=> (hrdata_out == '0);
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside data phase");

  c_rise_irq: cover property (rise_ev && q.ctl.intp ##1 irq_out);
  c_fall_irq: cover property (fall_ev && q.ctl.intn);
  c_inv_flip: cover property (q.ctl.en && $changed(q.pol.out_inv) ##1 edge_ev);
  c_ctl_read: cover property (addr_ok && !hwrite_in && haddr_in[7:0] == `LCP_OFF_CTL);

endmodule // lcp_cell

// ### rtl/lcp_params.svh
`ifndef LCP_PARAMS_SVH
`define LCP_PARAMS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define LCP_OFF_CTL 8'h00
`define LCP_OFF_POL 8'h04
`define LCP_OFF_STAT 8'h08
`define LCP_OFF_MASK 8'h0C

// ****************************************
// field positions
// ****************************************
`define LCP_CTL_EN 7
`define LCP_CTL_OE 6
`define LCP_CTL_OUT 5
`define LCP_CTL_INTP 4
`define LCP_CTL_INTN 3
`define LCP_CTL_MODE_HI 2
`define LCP_CTL_MODE_LO 0
`define LCP_POL_INV 7
`define LCP_POL_GATE_HI 3
`define LCP_POL_GATE_LO 0
`define LCP_STAT_FLAG 0

// ****************************************
// reset values and bus constants
// ****************************************
`define LCP_CTL_RST 8'h00
`define LCP_BYTE_ZERO 8'h00
`define LCP_PAD_ZERO 24'h00_0000
`define LCP_WORD_ZERO 32'h0000_0000
`define LCP_HSIZE_WORD 3'h2
`define LCP_HRESP_OKAY 1'b0

`endif

// ### rtl/lcp_pkg.sv
package lcp_pkg;

  // logic function codes of the cell
  typedef enum logic [2:0] {
    LCP_MODE_AND_OR = 3'h0,
    LCP_MODE_OR_XOR = 3'h1,
    LCP_MODE_AND4 = 3'h2,
    LCP_MODE_SR_LATCH = 3'h3,
    LCP_MODE_DFF_SR = 3'h4,
    LCP_MODE_DFF2_R = 3'h5,
    LCP_MODE_JK_R = 3'h6,
    LCP_MODE_LATCH_SR = 3'h7
  } lcp_mode_t;

  // writable part of the control register
  typedef struct packed {
    logic en;
    logic oe;
    logic intp;
    logic intn;
    lcp_mode_t mode;
  } lcp_ctl_t;

  // polarity register, implemented bits only
  typedef struct packed {
    logic out_inv;
    logic [3:0] gate_inv;
  } lcp_pol_t;

  // whole state of the top module
  typedef struct packed {
    lcp_ctl_t ctl;
    lcp_pol_t pol;
    logic cell_out;
    logic out_prev;
    logic irq_flag;
    logic irq_mask;
    logic irq;
    logic pin_oe_n;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
  } lcp_state_t;

  // state of the logic function stage
  typedef struct packed {
    logic g1_prev;
    logic q;
  } lcp_fn_state_t;

endpackage

// ### rtl/lcp_func.sv
`timescale 1ns/1ps
`include "lcp_params.svh"

module lcp_func import lcp_pkg::*; (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic clear_in,
  input wire lcp_mode_t mode_in,
  input wire logic [3:0] gate_in,
  output logic result_out
);

  lcp_fn_state_t q, d;
  logic g1, g2, g3, g4, clk_rise;

  // ****************************************
  // function stage
  // ****************************************

  // stored modes show the updated value in the same cycle, so latches stay transparent
  always_comb begin
    d = q;
    g1 = gate_in[0];
    g2 = gate_in[1];
    g3 = gate_in[2];
    g4 = gate_in[3];
    clk_rise = g1 & ~q.g1_prev;
    d.g1_prev = g1;
    result_out = 1'b0;
    case (mode_in)
      LCP_MODE_AND_OR: result_out = (g1 & g2) | (g3 & g4);
      LCP_MODE_OR_XOR: result_out = (g1 | g2) ^ (g3 | g4);
      LCP_MODE_AND4: result_out = g1 & g2 & g3 & g4;
      LCP_MODE_SR_LATCH: begin
        // set dominates when both are high
        if (g1 | g2) begin
          d.q = 1'b1;
        end else if (g3 | g4) begin
          d.q = 1'b0;
        end
      end
      LCP_MODE_DFF_SR: begin
        if (g3) begin
          d.q = 1'b0;
        end else if (g4) begin
          d.q = 1'b1;
        end else if (clk_rise) begin
          d.q = g2;
        end
      end
      LCP_MODE_DFF2_R: begin
        if (g3) begin
          d.q = 1'b0;
        end else if (clk_rise) begin
          d.q = g2 & g4;
        end
      end
      LCP_MODE_JK_R: begin
        if (g3) begin
          d.q = 1'b0;
        end else if (clk_rise) begin
          case ({g2, g4})
            2'b10: d.q = 1'b1;
            2'b01: d.q = 1'b0;
            2'b11: d.q = ~q.q;
            default: d.q = q.q;
          endcase
        end
      end
      LCP_MODE_LATCH_SR: begin
        if (g3) begin
          d.q = 1'b0;
        end else if (g4) begin
          d.q = 1'b1;
        end else if (g1) begin
          d.q = g2;
        end
      end
      default: result_out = 1'b0;
    endcase
    // a disabled cell forgets its stored bit
    if (clear_in || !nrst_in) begin
      d.q = 1'b0;
    end
    if (mode_in inside {LCP_MODE_SR_LATCH, LCP_MODE_DFF_SR, LCP_MODE_DFF2_R, LCP_MODE_JK_R,
                        LCP_MODE_LATCH_SR}) begin
      result_out = d.q;
    end
  end

  // state register
  always_ff @(posedge mclk_in) begin
    q <= d;
  end

  // ****************************************
  // checks
  // ****************************************
  property p_and4;
    @(posedge mclk_in) disable iff (!nrst_in)
    (mode_in == LCP_MODE_AND4) |-> (result_out == (&gate_in));
  endproperty
  a_and4: assert property (p_and4) else $error("and4 mode result wrong");

  property p_dff_capture;
    @(posedge mclk_in) disable iff (!nrst_in)
    (mode_in == LCP_MODE_DFF_SR && !clear_in && !gate_in[2] && !gate_in[3] && gate_in[0] && !q.g1_prev)
      |-> (result_out == gate_in[1]);
  endproperty
  a_dff_capture: assert property (p_dff_capture) else $error("d flop missed its edge");

  property p_jk_reset;
    @(posedge mclk_in) disable iff (!nrst_in)
    (mode_in == LCP_MODE_JK_R && gate_in[2]) |-> !result_out ##1 (mode_in != LCP_MODE_JK_R || gate_in[0] || !result_out);
  endproperty
  a_jk_reset: assert property (p_jk_reset) else $error("jk reset not honoured");

  c_jk_toggle: cover property (@(posedge mclk_in) mode_in == LCP_MODE_JK_R && gate_in[1] && gate_in[3]
    && gate_in[0] && !q.g1_prev);

endmodule // lcp_func

// ### sim/lcp_cpu_model.sv
`timescale 1ns/1ps
`include "lcp_params.svh"

// ****************************************
// processor side of the register bus
// ****************************************
module lcp_cpu_model (
  input wire logic mclk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out
);
  // idle bus from time zero
  initial begin
    hsel_out = 1'b0;
    haddr_out = 32'hFFFF_FFFF;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = `LCP_HSIZE_WORD;
    hwdata_out = 32'hA5A5_5A5A;
  end

  // one single word transfer, entered just after a rising edge; waits on hready, no fixed count
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel_out <= 1'b1;
    haddr_out <= {24'h00_0000, a};
    htrans_out <= 2'h2;
    hwrite_out <= wr;
    hsize_out <= `LCP_HSIZE_WORD;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    hsel_out <= 1'b0;
    haddr_out <= ~{24'h00_0000, a};
    htrans_out <= 2'h0;
    hwdata_out <= wd;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    rd = hrdata_in;  // still the data-phase value here
    hwdata_out <= ~wd;  // released data must not look valid
  endtask

  // park the cell while function and polarity change, then enable it
  task automatic cfg(input logic [7:0] c, input logic [7:0] p);
    logic [31:0] d;
    xfer(1'b1, `LCP_OFF_CTL, {24'h00_0000, 1'h0, c[6:0]}, d);
    xfer(1'b1, `LCP_OFF_POL, {24'h00_0000, p}, d);
    xfer(1'b1, `LCP_OFF_CTL, {24'h00_0000, c}, d);
  endtask
endmodule  // lcp_cpu_model

// ### sim/tb_logic_cell_control_polarity.sv
`timescale 1ns/1ps
`include "lcp_params.svh"

// ****************************************
// bench: cell control and polarity stage
// ****************************************
module tb_logic_cell_control_polarity import lcp_pkg::*;;
  logic mclk, nrst, hsel, hwrite, hready, hresp, res, pdat, poe_n, irq;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] gate, gate_hold, g;
  logic [7:0] m_ctl, m_pol, paddr, c, p;
  logic m_out, m_prev, m_q, m_g1p, m_flag, m_mask, m_irq, m_poe, pend, st, cl, rnd_on, chk_on;
  integer errors = 0, n_compared = 0, seed = 85, i, r;

  lcp_cell dut (.mclk_in(mclk), .nrst_in(nrst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .gate_in(gate),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .cell_result_out(res),
    .pin_data_out(pdat), .pin_oe_n_out(poe_n), .irq_out(irq));
  lcp_cpu_model cpu (.mclk_in(mclk), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
    .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));

  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic close_out();
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp1(input logic a, input logic e, input string m);
    n_compared++;
    if (a !== e) begin
      errors++;
      $display("BAD %0t %s got %b exp %b", $time, m, a, e);
    end
  endtask

  task automatic cmp32(input logic [31:0] a, input logic [31:0] e, input string m);
    n_compared++;
    if (a !== e) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, a, e);
    end
  endtask

  // read one register; upper 24 bits must be zero
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] v;
    cpu.xfer(1'b0, a, 32'h0000_0000, v);
    cmp32(v, {24'h00_0000, e}, "register read");
  endtask

  // next function value; g is gates after inversion, p is gate 1 one clock back
  function automatic logic fn(input logic [2:0] md, input logic [3:0] g, input logic q, input logic p);
    logic ck;
    ck = g[0] & ~p;
    case (md)
      3'h0: fn = (g[0] & g[1]) | (g[2] & g[3]);
      3'h1: fn = (g[0] | g[1]) ^ (g[2] | g[3]);
      3'h2: fn = &g;
      3'h3: fn = (g[0] | g[1]) ? 1'b1 : ((g[2] | g[3]) ? 1'b0 : q);
      3'h4: fn = g[2] ? 1'b0 : (g[3] ? 1'b1 : (ck ? g[1] : q));
      3'h5: fn = g[2] ? 1'b0 : (ck ? (g[1] & g[3]) : q);
      3'h6: fn = g[2] ? 1'b0 : (ck ? ((g[1] & ~q) | (~g[3] & q)) : q);
      default: fn = g[2] ? 1'b0 : (g[3] ? 1'b1 : (g[0] ? g[1] : q));
    endcase
  endfunction

  // reference model, stepped at each rising edge from pre-edge values
  always @(posedge mclk) begin
    g = gate ^ m_pol[3:0];
    st = (m_out & ~m_prev & m_ctl[4]) | (~m_out & m_prev & m_ctl[3]);
    cl = pend && paddr == `LCP_OFF_STAT && hwdata[0];
    m_poe = ~(nrst & m_ctl[6]);
    if (!nrst) begin
      {m_ctl, m_out, m_prev, m_q, m_flag, m_mask, m_irq, pend} = '0;
    end else begin
      m_q = m_ctl[7] & fn(m_ctl[2:0], g, m_q, m_g1p);
      m_prev = m_out;
      m_out = m_ctl[7] & (m_q ^ m_pol[7]);
      m_flag = st | (m_flag & ~cl);
      // the line follows a mask written at this same edge
      if (pend && paddr == `LCP_OFF_MASK) m_mask = hwdata[0];
      m_irq = m_flag & m_mask;
      if (pend && paddr == `LCP_OFF_CTL) m_ctl = hwdata[7:0] & 8'hDF;
      if (pend && paddr == `LCP_OFF_POL) m_pol = hwdata[7:0] & 8'h8F;
      pend = hsel & htrans[1] & hwrite & (hsize == `LCP_HSIZE_WORD);
      paddr = haddr[7:0];
    end
    m_g1p = g[0];
  end

  // outputs compared every cycle, mid-cycle when settled
  always @(negedge mclk) if (chk_on) begin
    cmp1(res, m_out, "cell output");
    cmp1(pdat, m_out, "pin data");
    cmp1(poe_n, m_poe, "pin enable");
    cmp1(irq, m_irq, "interrupt");
    cmp1(hresp, `LCP_HRESP_OKAY, "bus response");
  end

  // gates: random while running, a held value while configuring
  always @(posedge mclk) gate <= rnd_on ? 4'($random(seed)) : gate_hold;

  // about 530 cycles expected; nearly twenty times that is a hang
  initial begin
    #50000;
    errors++;
    close_out();
  end

  initial begin
    nrst = 1'b0;
    gate = 4'h0;
    gate_hold = 4'h0;
    rnd_on = 1'b0;
    chk_on = 1'b0;
    repeat (6) @(posedge mclk);
    chk_on <= 1'b1;
    nrst <= 1'b1;
    @(posedge mclk);
    cpu.xfer(1'b1, `LCP_OFF_MASK, 32'h0000_0001, d);
    cpu.xfer(1'b1, `LCP_OFF_POL, 32'h0000_00F5, d);
    cpu.xfer(1'b1, `LCP_OFF_CTL, 32'h0000_0020, d);
    cpu.xfer(1'b1, 8'h10, 32'hFFFF_FFFF, d);
    rdchk(`LCP_OFF_POL, 8'h85);
    rdchk(`LCP_OFF_CTL, 8'h00);
    rdchk(8'h10, 8'h00);
    rdchk(`LCP_OFF_MASK, 8'h01);
    // every function code, cell enabled, random pin and interrupt enables and polarities
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      c = {1'h1, r[0], 1'h0, r[1], r[2], 3'(i)};
      p = r[15:8];
      rnd_on <= 1'b0;
      gate_hold <= {3'h0, p[0]};
      cpu.cfg(c, p);
      rnd_on <= 1'b1;
      repeat (40) @(posedge mclk);
      cpu.xfer(1'b1, `LCP_OFF_STAT, 32'h0000_0001, d);
      cpu.xfer(1'b1, `LCP_OFF_POL, {24'h00_0000, p ^ 8'h80}, d);
      rnd_on <= 1'b0;
      repeat (4) @(posedge mclk);
      rdchk(`LCP_OFF_CTL, {m_ctl[7:6], m_out, m_ctl[4:0]});
      rdchk(`LCP_OFF_POL, m_pol);
      rdchk(`LCP_OFF_STAT, {7'h00, m_flag});
    end
    // masked: flag sets, line stays low
    cpu.xfer(1'b1, `LCP_OFF_MASK, 32'h0000_0000, d);
    cpu.cfg(8'h9A, m_pol);
    cpu.xfer(1'b1, `LCP_OFF_STAT, 32'h0000_0001, d);
    cpu.xfer(1'b1, `LCP_OFF_POL, {24'h00_0000, m_pol ^ 8'h80}, d);
    repeat (4) @(posedge mclk);
    rdchk(`LCP_OFF_STAT, 8'h01);
    cpu.xfer(1'b1, `LCP_OFF_STAT, 32'h0000_0001, d);
    rdchk(`LCP_OFF_STAT, 8'h00);
    // reset in mid-run: control cleared, polarity kept
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rdchk(`LCP_OFF_CTL, 8'h00);
    rdchk(`LCP_OFF_POL, m_pol);
    rdchk(`LCP_OFF_MASK, 8'h00);
    close_out();
  end
endmodule  // tb_logic_cell_control_polarity
